//--- src/ppc_defines.svh
// Purpose: Offsets, field positions and reset values
// Assumes: Word index = byte address / 4
// Notes: Definitions only
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
// Register word indexes
`define PPC_IDX_CTL 6'h00
`define PPC_IDX_MODE 6'h01
`define PPC_IDX_ADDR 6'h02
`define PPC_IDX_PEN 6'h03
`define PPC_IDX_STAT 6'h04
`define PPC_IDX_DATA 6'h05
`define PPC_IDX_OUT2 6'h06
// port_control fields
`define PPC_CTL_EN 15
`define PPC_CTL_CS_FUNC 7:6
`define PPC_CTL_CS2P 4
`define PPC_CTL_CS1P 3
`define PPC_CTL_BE_POL 2
`define PPC_CTL_WR_POL 1
`define PPC_CTL_RD_POL 0
`define PPC_CTL_MASK 16'hbfff
// port_mode_timing fields
`define PPC_MD_BUSY 15
`define PPC_MD_EVT 14:13
`define PPC_MD_STEP 12:11
`define PPC_MD_WIDE 10
`define PPC_MD_MODE 9:8
`define PPC_MD_SETUP 7:6
`define PPC_MD_STRB 5:2
`define PPC_MD_HOLD 1:0
`define PPC_MODE_MASK 16'h7fff
// slave_buffer_status fields
`define PPC_ST_OVF 14
`define PPC_ST_UNF 6
// Codes
`define PPC_STEP_NONE 2'b00
`define PPC_STEP_UP 2'b01
`define PPC_STEP_DOWN 2'b10
`define PPC_STEP_BUF 2'b11
`define PPC_EVT_EACH 2'b01
`define PPC_EVT_LAST 2'b11
`define PPC_CS_BOTH 2'b10
`define PPC_CS_TWO 2'b01
`define PPC_LAST_BUF 2'b11
// Reset values
`define PPC_EMPTY_RST 4'hf
`define PPC_ZERO16 16'h0000
`endif

//--- src/ppc_parallel_port.sv
// Purpose: Control, timing and status of an 8-bit parallel port
// Assumes: Wishbone classic slave; one instruction cycle = one clk
// Notes: Pin inputs are synchronous to clk
// Overview of operation
// - Byte enable pin is active high when its polarity bit is one.
// - Write polarity sets write strobe, or enable strobe in master mode one.
// - Read polarity sets read strobe, or read/write strobe in master mode one.
// - Chip select polarity is ignored while those pins carry address bits.
// - Read-only busy flag is one while a master transfer runs; resets zero.
// - Event mode: none, every cycle, or buffer three; code 10 reserved.
// - Step mode adds or subtracts one from address, bit 14 kept.
// - Step mode 11 advances slave buffer pointers instead of address.
// - Wide option makes one data access run two byte transfers.
// - Mode field selects master one, master two, addressed or legacy slave.
// - Setup phase lasts setup code plus one cycles.
// - Strobe lasts one plus strobe code cycles; zero means one cycle.
// - Hold phase lasts hold code plus one cycles.
// - Setup and hold are skipped when strobe code is zero.
// - Address bit 15 or 14 acts as chip select per function field.
// - In slave modes the address register is the first output buffer.
// - Pin allocation bits hand each address pin to the port.
// - Input full flags set on write, clear on software read; summary.
// - Write to a full input byte sets sticky overflow until cleared.
// - Output empty flags reset one, clear on write, set when sent.
// - Read from an empty output byte sets sticky underflow until cleared.
// - Disable stops transfers and frees pins; enable resets buffer status.
// - Function field: 10 two selects, 01 select two, 00 address.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "ppc_defines.svh"
module ppc_parallel_port (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins sampled from the far side
  input wire logic chipSelectOnePin,
  input wire logic readStrobeIn,
  input wire logic writeStrobeIn,
  input wire logic [1:0] addressIn,
  input wire logic [7:0] dataPinsIn,
  // Pins driven toward the far side
  output logic [15:0] addressPins_q,
  output logic [15:0] pinOwn_q,
  output logic readStrobePin_q,
  output logic writeStrobePin_q,
  output logic strobeOeN_q,
  output logic byteEnablePin_q,
  output logic [7:0] dataPins_q,
  output logic dataOeN_q,
  output logic portEvent_q
);

  ////////////////////////////////////////////////////////////////
  // State
  logic [15:0] ctlQ;
  logic [15:0] modeQ;
  logic [15:0] penQ;
  logic [15:0] mDataQ;
  logic [7:0] outBufQ [4];
  logic [7:0] outBufD [4];
  logic [7:0] inBufQ [4];
  logic [7:0] inBufD [4];
  logic [3:0] inFullQ;
  logic [3:0] inFullD;
  logic [3:0] outEmptyQ;
  logic [3:0] outEmptyD;
  logic ovfQ;
  logic unfQ;
  ppc_pkg::ppc_state_e stateQ;
  ppc_pkg::ppc_state_e stateD;
  logic [3:0] cntQ;
  logic [3:0] cntD;
  logic busyQ;
  logic busyD;
  logic dirReadQ;
  logic byteSelQ;
  logic byteSelD;
  logic [1:0] wrPtrQ;
  logic [1:0] rdPtrQ;
  logic wrLvlQ;
  logic rdLvlQ;
  logic enPrevQ;

  function automatic logic [15:0] ppcMerge(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    ppcMerge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : ppcMerge

  ////////////////////////////////////////////////////////////////
  // Bus decode
  logic busAcc;
  logic busWr;
  logic busRd;
  logic [5:0] regIdx;
  logic wrCtl;
  logic wrMode;
  logic wrAddr;
  logic wrPen;
  logic wrStat;
  logic wrOut2;
  logic dataAcc;
  assign busAcc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr = busAcc & wb_we_i;
  assign busRd = busAcc & ~wb_we_i;
  assign regIdx = wb_adr_i[7:2];
  assign wrCtl = busWr & (regIdx == `PPC_IDX_CTL);
  assign wrMode = busWr & (regIdx == `PPC_IDX_MODE);
  assign wrAddr = busWr & (regIdx == `PPC_IDX_ADDR);
  assign wrPen = busWr & (regIdx == `PPC_IDX_PEN);
  assign wrStat = busWr & (regIdx == `PPC_IDX_STAT);
  assign wrOut2 = busWr & (regIdx == `PPC_IDX_OUT2);
  assign dataAcc = busAcc & (regIdx == `PPC_IDX_DATA);

  ////////////////////////////////////////////////////////////////
  // Configuration fields
  logic enabled;
  logic enRise;
  ppc_pkg::ppc_mode_e mode;
  logic isMaster;
  logic isSlave;
  logic addressed;
  logic buffered;
  logic wide;
  logic [1:0] stepMd;
  logic [1:0] evMd;
  logic [1:0] setup_wait;
  logic [3:0] strobe_wait;
  logic [1:0] hold_wait;
  logic [1:0] csFn;
  assign enabled = ctlQ[`PPC_CTL_EN];
  assign enRise = enabled & ~enPrevQ;
  assign mode = ppc_pkg::ppc_mode_e'(modeQ[`PPC_MD_MODE]);
  assign isMaster = (mode == ppc_pkg::PPC_MASTER1) | (mode == ppc_pkg::PPC_MASTER2);
  assign isSlave = enabled & ~isMaster;
  assign addressed = (mode == ppc_pkg::PPC_ADDRESSED);
  assign stepMd = modeQ[`PPC_MD_STEP];
  assign buffered = (stepMd == `PPC_STEP_BUF);
  assign evMd = modeQ[`PPC_MD_EVT];
  assign wide = modeQ[`PPC_MD_WIDE];
  assign setup_wait = modeQ[`PPC_MD_SETUP];
  assign strobe_wait = modeQ[`PPC_MD_STRB];
  assign hold_wait = modeQ[`PPC_MD_HOLD];
  assign csFn = ctlQ[`PPC_CTL_CS_FUNC];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctlQ <= `PPC_ZERO16;
      modeQ <= `PPC_ZERO16;
      penQ <= `PPC_ZERO16;
      enPrevQ <= 1'b0;
    end else begin
      ctlQ <= wrCtl ? (ppcMerge(ctlQ, wb_dat_i, wb_sel_i) & `PPC_CTL_MASK) : ctlQ;
      modeQ <= wrMode ? (ppcMerge(modeQ, wb_dat_i, wb_sel_i) & `PPC_MODE_MASK) : modeQ;
      penQ <= wrPen ? ppcMerge(penQ, wb_dat_i, wb_sel_i) : penQ;
      enPrevQ <= enabled;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Slave strobes and buffer indexes
  logic csAct;
  logic wrLvl;
  logic rdLvl;
  logic wrEv;
  logic rdEv;
  logic [1:0] wrIdx;
  logic [1:0] rdIdx;
  logic ovfSet;
  logic unfSet;
  assign csAct = (chipSelectOnePin == ctlQ[`PPC_CTL_CS1P]);
  assign wrLvl = isSlave & csAct & (writeStrobeIn == ctlQ[`PPC_CTL_WR_POL]);
  assign rdLvl = isSlave & csAct & (readStrobeIn == ctlQ[`PPC_CTL_RD_POL]);
  assign wrEv = wrLvl & ~wrLvlQ;
  assign rdEv = rdLvl & ~rdLvlQ;
  assign wrIdx = addressed ? addressIn : (buffered ? wrPtrQ : 2'b00);
  assign rdIdx = addressed ? addressIn : (buffered ? rdPtrQ : 2'b00);
  // Stale flags are being reset on enable, so no sticky event then
  assign ovfSet = wrEv & inFullQ[wrIdx] & ~enRise;
  assign unfSet = rdEv & outEmptyQ[rdIdx] & ~enRise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrLvlQ <= 1'b0;
      rdLvlQ <= 1'b0;
      wrPtrQ <= 2'b00;
      rdPtrQ <= 2'b00;
    end else begin
      wrLvlQ <= wrLvl;
      rdLvlQ <= rdLvl;
      if (enRise) begin
        wrPtrQ <= 2'b00;
        rdPtrQ <= 2'b00;
      end else begin
        wrPtrQ <= wrPtrQ + {1'b0, wrEv & buffered & ~addressed};
        rdPtrQ <= rdPtrQ + {1'b0, rdEv & buffered & ~addressed};
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Master transfer sequencer
  logic launch;
  logic strobeEnd;
  logic byteDone;
  logic lastByte;
  logic stepNow;
  logic [15:0] curAddr;
  logic [14:0] lowPart;
  logic [14:0] lowNext;
  logic [31:0] stepAddr;
  ppc_pkg::ppc_state_e firstState;
  logic [3:0] firstCnt;
  assign launch = dataAcc & isMaster & enabled & ~busyQ;
  assign strobeEnd = busyQ & (stateQ == ppc_pkg::PPC_STROBE) & (cntQ == 4'h0);
  assign byteDone = busyQ & (cntQ == 4'h0) & (((stateQ == ppc_pkg::PPC_STROBE) & (strobe_wait == 4'h0))
                    | (stateQ == ppc_pkg::PPC_HOLD));
  assign lastByte = ~wide | byteSelQ;
  assign firstState = (strobe_wait == 4'h0) ? ppc_pkg::PPC_STROBE : ppc_pkg::PPC_SETUP;
  assign firstCnt = (strobe_wait == 4'h0) ? 4'h0 : {2'b00, setup_wait};
  assign curAddr = {outBufQ[1], outBufQ[0]};
  assign lowPart = {curAddr[15], curAddr[13:0]};
  assign lowNext = (stepMd == `PPC_STEP_DOWN) ? lowPart - 15'h0001 : lowPart + 15'h0001;
  assign stepAddr = {`PPC_ZERO16, lowNext[14], curAddr[14], lowNext[13:0]};
  assign stepNow = enabled & byteDone & ((stepMd == `PPC_STEP_UP) | (stepMd == `PPC_STEP_DOWN));

  always_comb begin
    stateD = stateQ;
    cntD = cntQ - 4'h1;
    busyD = busyQ;
    byteSelD = byteSelQ;
    unique case (stateQ)
      ppc_pkg::PPC_IDLE: begin
        cntD = cntQ;
        if (launch) begin
          stateD = firstState;
          cntD = firstCnt;
          busyD = 1'b1;
          byteSelD = 1'b0;
        end
      end
      ppc_pkg::PPC_SETUP: begin
        if (cntQ == 4'h0) begin
          stateD = ppc_pkg::PPC_STROBE;
          cntD = strobe_wait;
        end
      end
      ppc_pkg::PPC_STROBE: begin
        if (cntQ == 4'h0 && strobe_wait != 4'h0) begin
          stateD = ppc_pkg::PPC_HOLD;
          cntD = {2'b00, hold_wait};
        end
      end
      ppc_pkg::PPC_HOLD: begin
      end
    endcase
    if (byteDone) begin
      if (lastByte) begin
        stateD = ppc_pkg::PPC_IDLE;
        cntD = 4'h0;
        busyD = 1'b0;
      end else begin
        stateD = firstState;
        cntD = firstCnt;
        byteSelD = 1'b1;
      end
    end
    if (!enabled) begin
      stateD = ppc_pkg::PPC_IDLE;
      cntD = 4'h0;
      busyD = 1'b0;
      byteSelD = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stateQ <= ppc_pkg::PPC_IDLE;
      cntQ <= 4'h0;
      busyQ <= 1'b0;
      byteSelQ <= 1'b0;
      dirReadQ <= 1'b0;
      mDataQ <= `PPC_ZERO16;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      busyQ <= busyD;
      byteSelQ <= byteSelD;
      dirReadQ <= launch ? ~wb_we_i : dirReadQ;
      if (launch && wb_we_i) begin
        mDataQ <= ppcMerge(mDataQ, wb_dat_i, wb_sel_i);
      end else if (strobeEnd && dirReadQ) begin
        mDataQ[byteSelQ*8 +: 8] <= dataPinsIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Slave buffers, one slice per byte
  logic [3:0] inHit;
  logic [3:0] inClr;
  logic [3:0] outHit;
  logic [3:0] outSwWr;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gBuf
      localparam int L = gi % 2;
      logic swByte;
      assign swByte = ((gi < 2) ? wrAddr : wrOut2) & wb_sel_i[L];
      assign inHit[gi] = wrEv & (wrIdx == 2'(gi));
      assign inClr[gi] = dataAcc & ~wb_we_i & ~isMaster & wb_sel_i[gi];
      assign outHit[gi] = rdEv & (rdIdx == 2'(gi));
      assign outSwWr[gi] = swByte & ~isMaster;
      assign inFullD[gi] = inHit[gi] | (inFullQ[gi] & ~inClr[gi]);
      assign outEmptyD[gi] = outHit[gi] | (outEmptyQ[gi] & ~outSwWr[gi]);
      assign inBufD[gi] = (inHit[gi] & ~inFullQ[gi]) ? dataPinsIn : inBufQ[gi];
      assign outBufD[gi] = swByte ? wb_dat_i[L*8 +: 8]
                           : ((gi < 2 && stepNow) ? stepAddr[gi*8 +: 8] : outBufQ[gi]);
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inFullQ <= 4'h0;
      outEmptyQ <= `PPC_EMPTY_RST;
      ovfQ <= 1'b0;
      unfQ <= 1'b0;
      inBufQ <= '{default: 8'h00};
      outBufQ <= '{default: 8'h00};
    end else begin
      inBufQ <= inBufD;
      outBufQ <= outBufD;
      if (enRise) begin
        inFullQ <= 4'h0;
        outEmptyQ <= `PPC_EMPTY_RST;
        ovfQ <= 1'b0;
        unfQ <= 1'b0;
      end else begin
        inFullQ <= inFullD;
        outEmptyQ <= outEmptyD;
        ovfQ <= ovfSet | (ovfQ & ~(wrStat & wb_sel_i[1] & ~wb_dat_i[`PPC_ST_OVF]));
        unfQ <= unfSet | (unfQ & ~(wrStat & wb_sel_i[0] & ~wb_dat_i[`PPC_ST_UNF]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux and bus answer
  logic [15:0] statWord;
  logic [31:0] rdMux;
  assign statWord = {&inFullQ, ovfQ, 2'b00, inFullQ, &outEmptyQ, unfQ, 2'b00, outEmptyQ};
  assign rdMux = (regIdx == `PPC_IDX_CTL) ? {`PPC_ZERO16, ctlQ}
               : (regIdx == `PPC_IDX_MODE) ? {`PPC_ZERO16, busyQ, modeQ[14:0]}
               : (regIdx == `PPC_IDX_ADDR) ? {`PPC_ZERO16, curAddr}
               : (regIdx == `PPC_IDX_PEN) ? {`PPC_ZERO16, penQ}
               : (regIdx == `PPC_IDX_STAT) ? {`PPC_ZERO16, statWord}
               : (regIdx == `PPC_IDX_OUT2) ? {`PPC_ZERO16, outBufQ[3], outBufQ[2]}
               : (regIdx != `PPC_IDX_DATA) ? 32'h0000_0000
               : isMaster ? {`PPC_ZERO16, mDataQ}
               : {inBufQ[3], inBufQ[2], inBufQ[1], inBufQ[0]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busAcc;
      wb_dat_o <= busRd ? rdMux : wb_dat_o;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drive
  logic rdAct;
  logic wrAct;
  logic inStrobe;
  logic pin15;
  logic pin14;
  logic evEach;
  logic evLast;
  assign inStrobe = busyQ & (stateQ == ppc_pkg::PPC_STROBE);
  assign rdAct = (mode == ppc_pkg::PPC_MASTER1) ? (busyQ & dirReadQ) : (inStrobe & dirReadQ);
  assign wrAct = (mode == ppc_pkg::PPC_MASTER1) ? inStrobe : (inStrobe & ~dirReadQ);
  assign pin15 = ((csFn == `PPC_CS_BOTH) | (csFn == `PPC_CS_TWO))
                 ? (curAddr[15] ~^ ctlQ[`PPC_CTL_CS2P]) : curAddr[15];
  assign pin14 = (csFn == `PPC_CS_BOTH)
                 ? (curAddr[14] ~^ ctlQ[`PPC_CTL_CS1P]) : curAddr[14];
  assign evEach = (evMd == `PPC_EVT_EACH) & ((byteDone & lastByte) | wrEv | rdEv);
  assign evLast = (evMd == `PPC_EVT_LAST) & (buffered | addressed)
                  & ((wrEv & (wrIdx == `PPC_LAST_BUF)) | (rdEv & (rdIdx == `PPC_LAST_BUF)));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addressPins_q <= `PPC_ZERO16;
      pinOwn_q <= `PPC_ZERO16;
      readStrobePin_q <= 1'b0;
      writeStrobePin_q <= 1'b0;
      strobeOeN_q <= 1'b1;
      byteEnablePin_q <= 1'b0;
      dataPins_q <= 8'h00;
      dataOeN_q <= 1'b1;
      portEvent_q <= 1'b0;
    end else begin
      addressPins_q <= {pin15, pin14, curAddr[13:0]};
      pinOwn_q <= enabled ? penQ : `PPC_ZERO16;
      readStrobePin_q <= rdAct ~^ ctlQ[`PPC_CTL_RD_POL];
      writeStrobePin_q <= wrAct ~^ ctlQ[`PPC_CTL_WR_POL];
      strobeOeN_q <= ~(enabled & isMaster);
      byteEnablePin_q <= (busyQ & wide) ~^ ctlQ[`PPC_CTL_BE_POL];
      dataPins_q <= rdEv ? outBufQ[rdIdx] : ((busyQ & ~dirReadQ) ? mDataQ[byteSelQ*8 +: 8] : dataPins_q);
      dataOeN_q <= ~((busyQ & ~dirReadQ) | rdLvl);
      portEvent_q <= evEach | evLast;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence setupTwo;
    (stateQ == ppc_pkg::PPC_SETUP) [*2];
  endsequence
  sequence holdThree;
    (stateQ == ppc_pkg::PPC_HOLD) [*3];
  endsequence

  disable_stops_a: assert property (!enabled |=> !busyQ)
    else $error("busy still set while disabled");
  launch_busy_a: assert property (launch |=> busyQ)
    else $error("busy not set after launch");
  single_strobe_a: assert property (launch && strobe_wait == 4'h0 && !wide && enabled
    |=> stateQ == ppc_pkg::PPC_STROBE ##1 !busyQ)
    else $error("zero strobe code not a single cycle");
  setup_len_a: assert property (launch && strobe_wait != 4'h0 && setup_wait == 2'b01
    |=> setupTwo ##1 stateQ == ppc_pkg::PPC_STROBE)
    else $error("setup phase length wrong");
  hold_len_a: assert property (strobeEnd && strobe_wait != 4'h0 && hold_wait == 2'b10 && enabled
    |=> holdThree)
    else $error("hold phase length wrong");
  overflow_flag_a: assert property (ovfSet |=> ovfQ)
    else $error("overflow not flagged");
  underflow_flag_a: assert property (unfSet |=> unfQ)
    else $error("underflow not flagged");
  address_step_a: assert property (stepNow && stepMd == `PPC_STEP_UP && !wrAddr
    |=> lowPart == $past(lowPart) + 15'h0001 && curAddr[14] == $past(curAddr[14]))
    else $error("address step wrong");
  input_clear_a: assert property (inClr[0] && !inHit[0] && !enRise |=> !inFullQ[0])
    else $error("input full not cleared by read");

endmodule : ppc_parallel_port

//--- src/ppc_pkg.sv
// Purpose: Types of the parallel port control block
// Assumes: Nothing
// Notes: Encodings are fixed binary codes
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_LEGACY = 2'b00,
    PPC_ADDRESSED = 2'b01,
    PPC_MASTER2 = 2'b10,
    PPC_MASTER1 = 2'b11
  } ppc_mode_e;
  typedef enum logic [1:0] {
    PPC_IDLE = 2'b00,
    PPC_SETUP = 2'b01,
    PPC_STROBE = 2'b10,
    PPC_HOLD = 2'b11
  } ppc_state_e;
endpackage : ppc_pkg

//--- tb/ppc_far_side.sv
// Purpose: Far-side host and peripheral model
// Assumes: Host strobes and chip select active high
// Notes: Released data lines toggle each cycle
`timescale 1ns/100ps
module ppc_far_side (
  // Clock
  input wire logic clk,
  // From the port
  input wire logic [7:0] dataPins_q,
  input wire logic dataOeN_q,
  input wire logic readStrobePin_q,
  // Reply setup
  input wire logic rdAct,
  input wire logic [7:0] reply,
  // Toward the port
  output logic cs,
  output logic rd,
  output logic wr,
  output logic [1:0] adr,
  output logic [7:0] din
);
  logic [7:0] drv, hostByte, got;
  logic hostDrv;
  initial begin
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 2'h0;
    drv = 8'h00;
    hostByte = 8'h00;
    hostDrv = 1'b0;
  end
  // Wire level from both enables
  assign din = !dataOeN_q ? dataPins_q : (hostDrv ? hostByte : drv);
  // Reply only while the read strobe is active
  always @(posedge clk) begin
    drv <= (readStrobePin_q === rdAct) ? reply : ~drv;
  end
  // One host access, may hit a full or empty byte
  task automatic strobe(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1;
    adr <= a;
    wr <= w;
    rd <= !w;
    hostByte <= d;
    hostDrv <= w;
    repeat (4) @(posedge clk);
    got = din;
    cs <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    hostDrv <= 1'b0;
    @(posedge clk);
  endtask : strobe
endmodule : ppc_far_side

//--- tb/ppc_parallel_port_bench.sv
// Purpose: Self-checking bench of the parallel port
// Assumes: One ack per bus request
// Notes: Register reads are checked by a queue monitor
`timescale 1ns/100ps
module ppc_parallel_port_bench;
  logic clk, nrst, cyc, stb, we, ack, cs, rd, wr, oeN, bePin, rsPin, wsPin, soeN, ev, rdAct, wLvl;
  logic [1:0] sadr;
  logic [7:0] adr, din, dout, reply, lastOut;
  logic [7:0] b[4];
  logic [3:0] sel, lanes;
  logic [15:0] aPins, own, rnd;
  logic [31:0] wdat, datO, rdat;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [31:0] cTab[3];
  int miscompares, n_checks, wCnt, oeCnt, beCnt, evCnt;
  ppc_parallel_port u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
    .chipSelectOnePin(cs), .readStrobeIn(rd), .writeStrobeIn(wr), .addressIn(sadr), .dataPinsIn(din),
    .addressPins_q(aPins), .pinOwn_q(own), .readStrobePin_q(rsPin), .writeStrobePin_q(wsPin),
    .strobeOeN_q(soeN), .byteEnablePin_q(bePin), .dataPins_q(dout), .dataOeN_q(oeN), .portEvent_q(ev));
  ppc_far_side u_far (.clk(clk), .dataPins_q(dout), .dataOeN_q(oeN), .readStrobePin_q(rsPin),
    .rdAct(rdAct), .reply(reply), .cs(cs), .rd(rd), .wr(wr), .adr(sadr), .din(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask : rdReg
  task automatic idle();
    do begin
      rdReg(8'h04, 32'h0, 32'h0);
    end while (rdat[15] !== 1'b0);
  endtask : idle
  task automatic zero();
    @(negedge clk);
    wCnt = 0;
    oeCnt = 0;
    beCnt = 0;
    evCnt = 0;
  endtask : zero
  ////////////////////////////////////////////////////////////////////////////////
  // Read result monitor and pin counters
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      check(datO & mskQ.pop_front(), expQ.pop_front());
    end
    if (wsPin === wLvl) wCnt++;
    if (oeN === 1'b0) oeCnt++;
    if (bePin === 1'b1) beCnt++;
    if (ev === 1'b1) evCnt++;
    if (oeN === 1'b0 && wsPin === wLvl) lastOut = dout;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    lanes = 4'hf;
    rdAct = 1'b0;
    reply = 8'h00;
    wLvl = 1'b1;
    miscompares = 0;
    n_checks = 0;
    rnd = 16'h5f34;
    cTab = '{32'h8048_4000, 32'h8080_0000, 32'h8000_c000};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdReg(8'h10, 32'h8f, 32'hffff);
    rdReg(8'h04, 32'h0, 32'hffff);
    rdReg(8'h3c, 32'h0, 32'hffff_ffff);
    check({31'h0, rsPin}, 32'h1);
    $display("reset test done");
    // Master two write with all three phases
    wrReg(8'h0c, 32'hffff);
    wrReg(8'h00, 32'h801f);
    wrReg(8'h04, 32'h2a49);
    wrReg(8'h08, 32'h1234);
    rnd = lfsr(rnd);
    zero();
    wrReg(8'h14, {24'h0, rnd[7:0]});
    rdReg(8'h04, 32'h8000, 32'h8000);
    check({31'h0, soeN}, 32'h0);
    idle();
    check(wCnt, 32'h3);
    check(oeCnt, 32'h7);
    check({24'h0, lastOut}, {24'h0, rnd[7:0]});
    check(evCnt, 32'h1);
    check({16'h0, own}, 32'hffff);
    check({16'h0, aPins}, 32'h1235);
    // Wide write, single-cycle strobes, step down across bit 14
    wrReg(8'h04, 32'h16c3);
    wrReg(8'h08, 32'h4000);
    rnd = lfsr(rnd);
    zero();
    wrReg(8'h14, {16'h0, rnd});
    idle();
    check(wCnt, 32'h2);
    check(oeCnt, 32'h2);
    check(beCnt, 32'h2);
    check(evCnt, 32'h0);
    check({24'h0, lastOut}, {24'h0, rnd[15:8]});
    rdReg(8'h08, 32'hfffe, 32'hffff);
    $display("master write test done");
    // Master one read, active-low strobes
    rnd = lfsr(rnd);
    reply = rnd[7:0];
    wLvl = 1'b0;
    wrReg(8'h00, 32'h8018);
    wrReg(8'h04, 32'h030e);
    zero();
    rdReg(8'h14, 32'h0, 32'h0);
    idle();
    check(wCnt, 32'h4);
    check(oeCnt, 32'h0);
    check({31'h0, bePin}, 32'h1);
    rdReg(8'h14, {24'h0, rnd[7:0]}, 32'hff);
    idle();
    rdReg(8'h08, 32'hfffe, 32'hffff);
    // Chip select function codes
    wrReg(8'h08, 32'hc000);
    foreach (cTab[i]) begin
      wrReg(8'h00, {16'h0, cTab[i][31:16]});
      @(posedge clk);
      check({16'h0, aPins}, {16'h0, cTab[i][15:0]});
    end
    $display("master read test done");
    // Buffered slave
    wLvl = 1'b1;
    wrReg(8'h00, 32'h0);
    @(posedge clk);
    check({16'h0, own}, 32'h0);
    wrReg(8'h04, 32'h7800);
    wrReg(8'h00, 32'h800b);
    zero();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      b[i] = rnd[7:0];
      u_far.strobe(1'b1, 2'h0, b[i]);
    end
    check(evCnt, 32'h1);
    rdReg(8'h10, 32'h8f8f, 32'hffff);
    u_far.strobe(1'b1, 2'h0, 8'h5a);
    rdReg(8'h10, 32'hcf8f, 32'hffff);
    rdReg(8'h14, {b[3], b[2], b[1], b[0]}, 32'hffff_ffff);
    rdReg(8'h10, 32'h408f, 32'hffff);
    wrReg(8'h10, 32'h0);
    rdReg(8'h10, 32'h8f, 32'hffff);
    wrReg(8'h08, 32'h2211);
    rdReg(8'h10, 32'hc, 32'hffff);
    for (int i = 0; i < 3; i++) begin
      u_far.strobe(1'b0, 2'h0, 8'h00);
      if (i < 2) check({24'h0, u_far.got}, {24'h0, 8'h11 * 8'(i + 1)});
    end
    rdReg(8'h10, 32'hcf, 32'hffff);
    wrReg(8'h00, 32'h0);
    rdReg(8'h10, 32'hcf, 32'hffff);
    wrReg(8'h00, 32'h800b);
    rdReg(8'h10, 32'h8f, 32'hffff);
    $display("buffered slave test done");
    // Addressed slave, byte three
    wrReg(8'h04, 32'h6100);
    zero();
    u_far.strobe(1'b1, 2'h3, 8'ha5);
    check(evCnt, 32'h1);
    rdReg(8'h10, 32'h088f, 32'hffff);
    // Lane-wise clear: byte three stays full until its lane is read
    lanes = 4'h7;
    rdReg(8'h14, 32'h0, 32'h0);
    rdReg(8'h10, 32'h088f, 32'hffff);
    lanes = 4'hf;
    rdReg(8'h14, 32'ha500_0000, 32'hff00_0000);
    rdReg(8'h10, 32'h008f, 32'hffff);
    $display("addressed slave test done");
    report_and_stop();
  end
endmodule : ppc_parallel_port_bench
